// ---- design/video_sync_pkg.sv ----
// Package with offsets, field positions, reset values and timing for the video sync port.
package video_sync_pkg;
  // Register offsets on the host I/O port.
  localparam logic [15:0] DISP_STATUS_ADDR = 16'h02E8;
  localparam logic [15:0] H_ALT_BLANK_START_ADDR = 16'h32E8;
  localparam logic [15:0] H_ALT_BLANK_END_ADDR = 16'h36E8;
  localparam logic [15:0] V_ALT_BLANK_START_ADDR = 16'h3AE8;
  localparam logic [15:0] V_ALT_BLANK_END_ADDR = 16'h3EE8;
  localparam logic [15:0] ADV_FUNC_CTRL_ADDR = 16'h4AE8;
  localparam logic [15:0] EXT_CONFIG_1_ADDR = 16'h56E8;
  localparam logic [15:0] EXT_CONFIG_2_ADDR = 16'h5AE8;
  // Sync polarity and interlace control.
  localparam logic [15:0] SYNC_CTRL_ADDR = 16'h7EE8;
  // Palette port windows, low twelve address bits only.
  localparam logic [11:0] PAL_ACCEL_LO = 12'h2EA;
  localparam logic [11:0] PAL_ACCEL_HI = 12'h2ED;
  localparam logic [11:0] PAL_VGA_LO = 12'h3C6;
  localparam logic [11:0] PAL_VGA_HI = 12'h3C9;
  // Field positions.
  localparam int SENSE_BIT = 0;
  localparam int ADV_FUNC_BIT = 0;
  localparam int EC1_VGA_PAL_BIT = 15;
  localparam int EC1_FIELD_EN_BIT = 7;
  localparam int EC1_WIDE_WE_BIT = 3;
  localparam int EC2_DAC_WIDTH_BIT = 13;
  localparam int EC2_ALT_BLANK_BIT = 11;
  localparam int HSYNC_POL_BIT = 0;
  localparam int VSYNC_POL_BIT = 1;
  localparam int INTERLACE_BIT = 2;
  // Values after reset.
  localparam logic [15:0] EXT_CONFIG_1_RST = 16'h0000;
  localparam logic [15:0] EXT_CONFIG_2_RST = 16'h0000;
  localparam logic [2:0] SYNC_CTRL_RST = 3'h0;
  localparam logic [11:0] ALT_BLANK_RST = 12'h000;
  // Default raster timing in nugget clocks and lines.
  localparam int H_TOTAL_DEF = 800;
  localparam int H_DISP_DEF = 640;
  localparam int H_SYNC_START_DEF = 656;
  localparam int H_SYNC_WIDTH_DEF = 96;
  localparam int V_TOTAL_DEF = 525;
  localparam int V_DISP_DEF = 480;
  localparam int V_SYNC_START_DEF = 490;
  localparam int V_SYNC_WIDTH_DEF = 2;
endpackage : video_sync_pkg

// ---- design/video_sync_palette_port.sv ----
// Video sync, blank, palette strobe and strap logic of the accelerator's video interface.
//
// Functional notes
// RULE1: Read strobe on enabled palette port reads.
// RULE2: Pass-through also decodes VGA palette range.
// RULE3: Write strobe on enabled palette port writes.
// RULE4: Palette strobes tristated while reset applied.
// RULE5: DAC-width pin sampled, then driven from bit.
// RULE6: Alternate config drives DAC pin as blank.
// RULE7: Syncs and blank generated, programmable, tristated.
// RULE8: Non-advanced mode passes external VGA syncs.
// RULE9: Sense level readable as status bit zero.
// RULE10: Field parity output driven only when enabled.
// RULE11: Inverted field pin latched at reset.
// RULE12: Advanced mode follows control bit zero.
// RULE13: Horizontal sync registered on falling edge.
// RULE14: Strobes idle high outside decoded cycles.
`timescale 1ns/100ps
module video_sync_palette_port
  import video_sync_pkg::*;
#(
  parameter int H_TOTAL = H_TOTAL_DEF,
  parameter int H_DISP = H_DISP_DEF,
  parameter int H_SYNC_START = H_SYNC_START_DEF,
  parameter int H_SYNC_WIDTH = H_SYNC_WIDTH_DEF,
  parameter int V_TOTAL = V_TOTAL_DEF,
  parameter int V_DISP = V_DISP_DEF,
  parameter int V_SYNC_START = V_SYNC_START_DEF,
  parameter int V_SYNC_WIDTH = V_SYNC_WIDTH_DEF
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wstrb,
  input wire logic rstrb,
  output logic [15:0] rdata,
  input wire logic accel_enabled,
  output logic palette_read_strobe_n,
  output logic palette_read_oe,
  output logic palette_write_strobe_n,
  output logic palette_write_oe,
  output logic hsync_out,
  output logic hsync_oe,
  output logic vsync_out,
  output logic vsync_oe,
  output logic blank_n,
  output logic blank_oe,
  input wire logic ext_hsync_in,
  input wire logic ext_vsync_in,
  input wire logic dac_width_select_in,
  output logic dac_width_select_out,
  output logic dac_width_select_oe,
  input wire logic field_parity_in,
  output logic field_parity_out,
  output logic field_parity_oe,
  input wire logic sense_in,
  output logic advanced_function_mode
);

  // True when the low twelve address bits fall in a palette window.
  function automatic logic pal_hit(input logic [15:0] a, input logic vga_en);
    logic [11:0] low;
    // Only the low twelve bits count, so aliases in higher I/O pages decode too.
    low = a[11:0];
    pal_hit = ((low >= PAL_ACCEL_LO) && (low <= PAL_ACCEL_HI)) ||
              (vga_en && (low >= PAL_VGA_LO) && (low <= PAL_VGA_HI));
  endfunction : pal_hit

  // Software-visible registers.
  // Bits 15 and 7 of the first word and 13 and 11 of the second steer the pins.
  logic [15:0] ext_config_1_q;
  logic [15:0] ext_config_2_q;
  logic advanced_function_control_q;
  logic [2:0] sync_ctrl_q;
  logic [11:0] h_ab_start_q;
  logic [11:0] h_ab_end_q;
  logic [11:0] v_ab_start_q;
  logic [11:0] v_ab_end_q;
  // Raster counters and internal timing levels.
  logic [11:0] h_cnt_q;
  logic [11:0] v_cnt_q;
  logic field_q;
  logic hsync_int_d;
  logic vsync_int_d;
  logic blank_int_d;
  logic alt_blank_d;
  logic hit;
  logic end_of_line;
  logic end_of_frame;

  // Palette decode is shared by both strobes.
  assign hit = pal_hit(addr, ext_config_1_q[EC1_VGA_PAL_BIT]);  // [RULE2]
  // Line and frame ends are single-cycle markers taken from the counters.
  assign end_of_line = (h_cnt_q == 12'(H_TOTAL - 1));
  assign end_of_frame = end_of_line && (v_cnt_q == 12'(V_TOTAL - 1));

  // Palette strobes go low for the cycle after a decoded access, high otherwise.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // The strobes float in reset; their level is parked high for release.
      palette_read_strobe_n <= 1'b1;
      palette_write_strobe_n <= 1'b1;
      palette_read_oe <= 1'b0;  // [RULE4]
      palette_write_oe <= 1'b0;  // [RULE4]
    end else begin
      // Both strobes are driven from the first edge after release.
      palette_read_oe <= 1'b1;
      palette_write_oe <= 1'b1;
      // Registering the strobes keeps them glitch-free while the address settles.
      palette_read_strobe_n <= !(accel_enabled && rstrb && hit);  // [RULE1] [RULE14]
      palette_write_strobe_n <= !(accel_enabled && wstrb && hit);  // [RULE3] [RULE14]
    end
  end

  // Configuration register writes, with strap capture while reset is held.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Straps are sampled on every reset edge, so the last one counts.
      ext_config_1_q <= EXT_CONFIG_1_RST;
      ext_config_1_q[EC1_WIDE_WE_BIT] <= !field_parity_in;  // [RULE11]
      ext_config_2_q <= EXT_CONFIG_2_RST;
      ext_config_2_q[EC2_DAC_WIDTH_BIT] <= dac_width_select_in;  // [RULE5]
      advanced_function_control_q <= 1'b0;
      sync_ctrl_q <= SYNC_CTRL_RST;
    end else if (wstrb) begin
      // Each write replaces the whole addressed register.
      // Software may overwrite the sampled strap bits afterwards.
      case (addr)
        EXT_CONFIG_1_ADDR: ext_config_1_q <= wdata;
        EXT_CONFIG_2_ADDR: ext_config_2_q <= wdata;
        ADV_FUNC_CTRL_ADDR: advanced_function_control_q <= wdata[ADV_FUNC_BIT];  // [RULE12]
        SYNC_CTRL_ADDR: sync_ctrl_q <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // Alternate blank window registers are write-only.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      h_ab_start_q <= ALT_BLANK_RST;
      h_ab_end_q <= ALT_BLANK_RST;
      v_ab_start_q <= ALT_BLANK_RST;
      v_ab_end_q <= ALT_BLANK_RST;
    end else if (wstrb) begin
      // Writes to other addresses leave the window unchanged.
      // New bounds take effect at the next raster comparison.
      case (addr)
        H_ALT_BLANK_START_ADDR: h_ab_start_q <= wdata[11:0];
        H_ALT_BLANK_END_ADDR: h_ab_end_q <= wdata[11:0];
        V_ALT_BLANK_START_ADDR: v_ab_start_q <= wdata[11:0];
        V_ALT_BLANK_END_ADDR: v_ab_end_q <= wdata[11:0];
        default: ;
      endcase
    end
  end

  // Read data appears the cycle after the read strobe; other cycles read zero.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rstrb) begin
      // Unmapped and write-only addresses return zero.
      case (addr)
        DISP_STATUS_ADDR: rdata <= {15'h0000, sense_in};  // [RULE9]
        EXT_CONFIG_1_ADDR: rdata <= ext_config_1_q;
        EXT_CONFIG_2_ADDR: rdata <= ext_config_2_q;
        ADV_FUNC_CTRL_ADDR: rdata <= {15'h0000, advanced_function_control_q};
        SYNC_CTRL_ADDR: rdata <= {13'h0000, sync_ctrl_q};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      // Data stands for one cycle only, then the bus reads zero again.
      rdata <= 16'h0000;
    end
  end

  // Raster counters and field parity step on the rising nugget clock edge.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Counting restarts at the top-left corner of the raster.
      h_cnt_q <= 12'h000;
      v_cnt_q <= 12'h000;
      field_q <= 1'b0;
    end else begin
      // The pixel counter wraps after the last clock of a line.
      h_cnt_q <= end_of_line ? 12'h000 : h_cnt_q + 12'h001;  // [RULE13]
      // Lines advance once per line end and wrap at the frame end.
      if (end_of_line) begin
        v_cnt_q <= end_of_frame ? 12'h000 : v_cnt_q + 12'h001;
      end
      // Parity toggles per field only in interlaced operation.
      if (!sync_ctrl_q[INTERLACE_BIT]) begin
        field_q <= 1'b0;
      end else if (end_of_frame) begin
        field_q <= !field_q;
      end
    end
  end

  // Internal sync, blank and alternate blank levels, before polarity.
  always_comb begin
    // Each window is half-open: the start is inside, the end is not.
    hsync_int_d = (h_cnt_q >= 12'(H_SYNC_START)) &&
                  (h_cnt_q < 12'(H_SYNC_START + H_SYNC_WIDTH));
    vsync_int_d = (v_cnt_q >= 12'(V_SYNC_START)) &&
                  (v_cnt_q < 12'(V_SYNC_START + V_SYNC_WIDTH));
    blank_int_d = (h_cnt_q >= 12'(H_DISP)) || (v_cnt_q >= 12'(V_DISP));
    alt_blank_d = ((h_cnt_q >= h_ab_start_q) && (h_cnt_q < h_ab_end_q)) ||
                  ((v_cnt_q >= v_ab_start_q) && (v_cnt_q < v_ab_end_q));  // [RULE6]
  end

  // Vertical sync, blank and mode indication on the rising edge.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Vertical sync and blank float in reset; the parked levels are the idle ones.
      vsync_out <= 1'b0;
      vsync_oe <= 1'b0;  // [RULE7]
      blank_n <= 1'b1;
      blank_oe <= 1'b0;  // [RULE7]
      advanced_function_mode <= 1'b0;
    end else begin
      // Enables rise at the first edge after release.
      vsync_oe <= 1'b1;
      blank_oe <= 1'b1;
      advanced_function_mode <= advanced_function_control_q;  // [RULE12]
      // External VGA sync replaces ours outside advanced mode.
      if (advanced_function_control_q) begin
        vsync_out <= vsync_int_d ^ sync_ctrl_q[VSYNC_POL_BIT];  // [RULE7]
      end else begin
        vsync_out <= ext_vsync_in;  // [RULE8]
      end
      // Blank has a fixed active-low sense; only the syncs are programmable.
      blank_n <= !blank_int_d;  // [RULE7]
    end
  end

  // Horizontal sync is retimed on the falling edge, half a cycle late.
  always_ff @(negedge clock) begin
    if (!nrst) begin
      // The falling-edge flop still obeys the synchronous reset.
      hsync_out <= 1'b0;
      hsync_oe <= 1'b0;  // [RULE7]
    end else begin
      // Its enable changes on the falling edge, half a cycle apart from the others.
      hsync_oe <= 1'b1;
      // The same pass-through choice applies to the horizontal output.
      if (advanced_function_control_q) begin
        hsync_out <= hsync_int_d ^ sync_ctrl_q[HSYNC_POL_BIT];  // [RULE13]
      end else begin
        hsync_out <= ext_hsync_in;  // [RULE8]
      end
    end
  end

  // DAC-width pin and field parity pin drivers.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Both shared pins are released so their straps can be sampled.
      dac_width_select_out <= 1'b0;
      dac_width_select_oe <= 1'b0;
      field_parity_out <= 1'b0;
      field_parity_oe <= 1'b0;  // [RULE10]
    end else begin
      // The width pin is an output for good once reset is over.
      dac_width_select_oe <= 1'b1;
      // Alternate blank takes over the pin when selected.
      if (ext_config_2_q[EC2_ALT_BLANK_BIT]) begin
        dac_width_select_out <= !alt_blank_d;  // [RULE6]
      end else begin
        dac_width_select_out <= ext_config_2_q[EC2_DAC_WIDTH_BIT];  // [RULE5]
      end
      // Parity stays floating unless software enables it.
      field_parity_oe <= ext_config_1_q[EC1_FIELD_EN_BIT];  // [RULE10]
      field_parity_out <= field_q;  // [RULE10]
    end
  end

  // Checks kept beside the logic they guard.
  // Every property samples on the rising edge of the nugget clock.
  // Palette strobe checks come first.
  a_read_strobe_fires: assert property (@(posedge clock) disable iff (!nrst) // [RULE1]
    (accel_enabled && rstrb && hit) |=> !palette_read_strobe_n)
    else $error("Palette read strobe missed a decoded read.");
  a_vga_window_decode: assert property (@(posedge clock) disable iff (!nrst) // [RULE2]
    (accel_enabled && wstrb && addr[11:0] == PAL_VGA_LO && !ext_config_1_q[EC1_VGA_PAL_BIT])
    |=> palette_write_strobe_n)
    else $error("VGA palette range decoded without pass-through.");
  a_write_strobe_fires: assert property (@(posedge clock) disable iff (!nrst) // [RULE3]
    (accel_enabled && wstrb && hit) |=> !palette_write_strobe_n ##1
    (palette_write_strobe_n || $past(wstrb)))
    else $error("Palette write strobe wrong width.");
  a_strobe_tristate: assert property (@(posedge clock) // [RULE4]
    !nrst |=> (!palette_read_oe && !palette_write_oe))
    else $error("Palette strobes driven during reset.");
  a_dac_width_drive: assert property (@(posedge clock) disable iff (!nrst) // [RULE5]
    (!ext_config_2_q[EC2_ALT_BLANK_BIT] && $stable(ext_config_2_q))
    |=> (dac_width_select_out == ext_config_2_q[EC2_DAC_WIDTH_BIT]))
    else $error("DAC width pin does not follow its bit.");
  a_alt_blank_drive: assert property (@(posedge clock) disable iff (!nrst) // [RULE6]
    (ext_config_2_q[EC2_ALT_BLANK_BIT] && alt_blank_d) |=> !dac_width_select_out)
    else $error("Alternate blank not asserted low.");
  a_sync_tristate: assert property (@(posedge clock) // [RULE7]
    !nrst |=> (!vsync_oe && !blank_oe))
    else $error("Sync or blank driven during reset.");
  a_vga_passthrough: assert property (@(posedge clock) disable iff (!nrst) // [RULE8]
    (!advanced_function_control_q) |=> (vsync_out == $past(ext_vsync_in)))
    else $error("External vertical sync not passed through.");
  a_sense_readback: assert property (@(posedge clock) disable iff (!nrst) // [RULE9]
    (rstrb && addr == DISP_STATUS_ADDR) |=> (rdata[SENSE_BIT] == $past(sense_in)))
    else $error("Status read lost the sense level.");
  a_field_enable: assert property (@(posedge clock) disable iff (!nrst) // [RULE10]
    $past(!ext_config_1_q[EC1_FIELD_EN_BIT], 1) |-> !field_parity_oe)
    else $error("Field parity driven while disabled.");
  a_strap_capture: assert property (@(posedge clock) // [RULE11]
    (!nrst ##1 nrst) |-> (ext_config_1_q[EC1_WIDE_WE_BIT] == !$past(field_parity_in)))
    else $error("Field pin strap not latched inverted.");
  a_idle_strobes: assert property (@(posedge clock) disable iff (!nrst) // [RULE14]
    (!accel_enabled) |=> (palette_read_strobe_n && palette_write_strobe_n))
    else $error("Palette strobe asserted while disabled.");
  // Further checks on idle strobes, strobe enables, blank, vertical sync, mode and the field pin.
  a_read_idle_high: assert property (@(posedge clock) disable iff (!nrst) // [RULE14]
    !(accel_enabled && rstrb && hit) |=> palette_read_strobe_n)
    else $error("Palette read strobe asserted outside a decoded read.");
  a_write_idle_high: assert property (@(posedge clock) disable iff (!nrst) // [RULE14]
    !(accel_enabled && wstrb && hit) |=> palette_write_strobe_n)
    else $error("Palette write strobe asserted outside a decoded write.");
  a_strobe_drive_on: assert property (@(posedge clock) // [RULE14]
    nrst |=> (palette_read_oe && palette_write_oe))
    else $error("Palette strobes not driven after reset.");
  a_blank_follows: assert property (@(posedge clock) disable iff (!nrst) // [RULE7]
    blank_int_d |=> !blank_n)
    else $error("Blank not asserted outside the display window.");
  a_vsync_polarity: assert property (@(posedge clock) disable iff (!nrst) // [RULE7]
    (advanced_function_control_q && vsync_int_d && !sync_ctrl_q[VSYNC_POL_BIT]) |=> vsync_out)
    else $error("Vertical sync missing in advanced mode.");
  a_adv_mode_follow: assert property (@(posedge clock) disable iff (!nrst) // [RULE12]
    advanced_function_control_q |=> advanced_function_mode)
    else $error("Advanced mode output does not follow its bit.");
  a_field_drive: assert property (@(posedge clock) disable iff (!nrst) // [RULE10]
    ext_config_1_q[EC1_FIELD_EN_BIT] |=>
    (field_parity_oe && (field_parity_out == $past(field_q))))
    else $error("Field parity not driven while enabled.");

endmodule : video_sync_palette_port

// ---- dv/video_sync_far_side_model.sv ----
// Far-side model: palette DAC strap pins, monitor sense and an external VGA sync source.
`timescale 1ns/100ps
module video_sync_far_side_model (
  input wire logic clock,
  input wire logic dac_width_select_out,
  input wire logic dac_width_select_oe,
  input wire logic field_parity_out,
  input wire logic field_parity_oe,
  input wire logic dac_strap,
  input wire logic field_strap,
  input wire logic sense_level,
  output logic dac_pin,
  output logic field_pin,
  output logic ext_hsync_in,
  output logic ext_vsync_in,
  output logic sense_in
);
  // Free-running divider that stands in for the external VGA raster.
  logic [2:0] vga_cnt_q = 3'h0;
  // The strap pull-up or pull-down wins only while the device releases the pin.
  assign dac_pin = dac_width_select_oe ? dac_width_select_out : dac_strap;
  assign field_pin = field_parity_oe ? field_parity_out : field_strap;
  assign sense_in = sense_level;
  // The external syncs only move just after a rising edge.
  always_ff @(posedge clock) begin
    vga_cnt_q <= vga_cnt_q + 3'h1;
    ext_hsync_in <= vga_cnt_q[1];
    ext_vsync_in <= vga_cnt_q[2];
  end
endmodule : video_sync_far_side_model

// ---- dv/video_sync_palette_port_tb.sv ----
// Self-checking testbench of the video sync and palette strobe port.
`timescale 1ns/100ps
module video_sync_palette_port_tb;
  import video_sync_pkg::*;
  logic clock, nrst, wstrb, rstrb, accel_enabled, dac_strap, field_strap, sense_level, e, eh;
  logic [15:0] addr, wdata, rdata, v;
  logic palette_read_strobe_n, palette_read_oe, palette_write_strobe_n, palette_write_oe;
  logic hsync_out, hsync_oe, vsync_out, vsync_oe, blank_n, blank_oe, advanced_function_mode;
  logic ext_hsync_in, ext_vsync_in, dac_pin, dac_width_select_out, dac_width_select_oe;
  logic field_pin, field_parity_out, field_parity_oe, sense_in;
  int errors = 0;
  int total_checks = 0;
  // Palette decode table: address and whether a strobe is expected.
  logic [15:0] pa [8] = '{16'h02E9, 16'h02EA, 16'h02EB, 16'h02EC, 16'h02ED, 16'h02EE,
    16'h12EB, 16'h03C6};
  logic pe [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  // Small raster: 20 clocks a line, 10 lines a frame, 200 clocks a frame.
  // Widths keep their defaults: hsync on clocks 14 to 19, vsync on lines 7 and 8,
  // blank on lines 6 to 9 only.
  video_sync_palette_port #(.H_TOTAL(20), .H_SYNC_START(14), .V_TOTAL(10), .V_DISP(6),
    .V_SYNC_START(7)) dut (.clock(clock),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wstrb(wstrb), .rstrb(rstrb), .rdata(rdata),
    .accel_enabled(accel_enabled), .palette_read_strobe_n(palette_read_strobe_n),
    .palette_read_oe(palette_read_oe), .palette_write_strobe_n(palette_write_strobe_n),
    .palette_write_oe(palette_write_oe), .hsync_out(hsync_out), .hsync_oe(hsync_oe),
    .vsync_out(vsync_out), .vsync_oe(vsync_oe), .blank_n(blank_n), .blank_oe(blank_oe),
    .ext_hsync_in(ext_hsync_in), .ext_vsync_in(ext_vsync_in), .dac_width_select_in(dac_pin),
    .dac_width_select_out(dac_width_select_out), .dac_width_select_oe(dac_width_select_oe),
    .field_parity_in(field_pin), .field_parity_out(field_parity_out),
    .field_parity_oe(field_parity_oe), .sense_in(sense_in),
    .advanced_function_mode(advanced_function_mode));
  video_sync_far_side_model far (.clock(clock), .dac_width_select_out(dac_width_select_out),
    .dac_width_select_oe(dac_width_select_oe), .field_parity_out(field_parity_out),
    .field_parity_oe(field_parity_oe), .dac_strap(dac_strap), .field_strap(field_strap),
    .sense_level(sense_level), .dac_pin(dac_pin), .field_pin(field_pin),
    .ext_hsync_in(ext_hsync_in), .ext_vsync_in(ext_vsync_in), .sense_in(sense_in));
  // Clock of 25 ns period.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Compares one value and reports a mismatch at once.
  task chk(input string n, input logic [15:0] s, input logic [15:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One-cycle register write; returns just after the edge that takes it.
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wstrb <= 1'b1;
    @(posedge clock);
    wstrb <= 1'b0;
    #1;
  endtask : wr
  // One-cycle register read; the answer stands only in the following cycle.
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a; rstrb <= 1'b1;
    @(posedge clock);
    rstrb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Counts the clocks over one frame in which the chosen output is high.
  task cnt(input int s, output logic [15:0] c);
    c = 16'h0000;
    // Two settling clocks let a just-written setting reach the pins.
    repeat (2) @(negedge clock);
    repeat (200) begin
      @(negedge clock);
      c = c + {15'h0, (s == 0) ? hsync_out : (s == 1) ? vsync_out :
        (s == 2) ? blank_n : dac_width_select_out};
    end
  endtask : cnt
  // Palette write then read at one address, with the strobe level expected.
  task pal(input logic [15:0] a, input logic x);
    wr(a, 16'h0055);
    chk("pal_wr", palette_write_strobe_n, !x);
    @(posedge clock);
    #1 chk("pal_idle", palette_write_strobe_n, 1'b1);
    rd(a, v);
    chk("pal_rd", palette_read_strobe_n, !x);
  endtask : pal
  // Prints the counts and the verdict, then ends the run.
  task print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the expected run of about 1500 clocks.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    nrst = 0; addr = 0; wdata = 0; wstrb = 0; rstrb = 0; accel_enabled = 0;
    dac_strap = 0; field_strap = 0; sense_level = 0;
    // Two resets, the second in mid-run with the opposite straps.
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      nrst <= 1'b0; dac_strap <= k[0]; field_strap <= k[0];
      repeat (2) @(posedge clock);
      #1 chk("pal_oe", {palette_read_oe, palette_write_oe}, 2'b00);
      chk("video_oe", {hsync_oe, vsync_oe, blank_oe}, 3'b000);
      chk("field_oe", field_parity_oe, 1'b0);
      @(posedge clock);
      nrst <= 1'b1;
      rd(EXT_CONFIG_2_ADDR, v);
      chk("ec2_width", v[EC2_DAC_WIDTH_BIT], k[0]);
      chk("dac_pin", {dac_width_select_oe, dac_width_select_out}, {1'b1, k[0]});
      chk("pal_oe_on", {palette_read_oe, palette_write_oe}, 2'b11);
      chk("video_oe_on", {hsync_oe, vsync_oe, blank_oe}, 3'b111);
      rd(EXT_CONFIG_1_ADDR, v);
      chk("ec1_wen", v[EC1_WIDE_WE_BIT], !k[0]);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      sense_level <= s[0];
      rd(DISP_STATUS_ADDR, v);
      chk("status", v, {15'h0, s[0]});
    end
    rd(H_ALT_BLANK_START_ADDR, v);
    chk("unread", v, 16'h0000);
    chk("adv_off", advanced_function_mode, 1'b0);
    @(negedge clock);
    e = ext_vsync_in;
    eh = ext_hsync_in;
    repeat (8) begin
      @(negedge clock);
      chk("vga_vsync", vsync_out, e);
      chk("vga_hsync", hsync_out, eh);
      e = ext_vsync_in;
      eh = ext_hsync_in;
    end
    pal(16'h02EB, 1'b0);
    @(posedge clock);
    accel_enabled <= 1'b1;
    for (int i = 0; i < 8; i++) pal(pa[i], pe[i]);
    wr(EXT_CONFIG_1_ADDR, 16'h8000);
    pal(16'h03C6, 1'b1);
    pal(16'h03C9, 1'b1);
    pal(16'h03C5, 1'b0);
    wr(ADV_FUNC_CTRL_ADDR, 16'h0001);
    @(posedge clock);
    #1 chk("adv_on", advanced_function_mode, 1'b1);
    cnt(0, v);
    chk("hsync_hi", v, 16'd60);
    cnt(1, v);
    chk("vsync_hi", v, 16'd40);
    cnt(2, v);
    chk("blank_hi", v, 16'd120);
    wr(SYNC_CTRL_ADDR, 16'h0003);
    cnt(0, v);
    chk("hsync_inv", v, 16'd140);
    cnt(1, v);
    chk("vsync_inv", v, 16'd160);
    wr(H_ALT_BLANK_START_ADDR, 16'h0002);
    wr(H_ALT_BLANK_END_ADDR, 16'h0005);
    wr(V_ALT_BLANK_START_ADDR, 16'h0000);
    wr(V_ALT_BLANK_END_ADDR, 16'h0000);
    wr(EXT_CONFIG_2_ADDR, 16'h2800);
    cnt(3, v);
    chk("alt_blank", v, 16'd170);
    wr(EXT_CONFIG_1_ADDR, 16'h0080);
    wr(SYNC_CTRL_ADDR, 16'h0004);
    chk("field_on", field_parity_oe, 1'b1);
    e = field_parity_out;
    // One extra clock covers the output lagging the field flip by a cycle.
    repeat (201) @(posedge clock);
    #1 chk("field_flip", field_parity_out, !e);
    print_verdict();
  end
endmodule : video_sync_palette_port_tb
